//--- hw/bds_cmd_decoder.sv
// command decoder for search, seek, set limits and start/stop unit behind APB
// assumes software loads the command block, then writes go; one command at a time
// Summary of operation
// - search ends satisfied at first record meeting every enabled descriptor
// - equal search matches on equal data, or unequal data when inverted
// - high search matches greater data, or less-or-equal when inverted
// - low search matches lesser data, or greater-or-equal when inverted
// - seek moves position to the command's block address, ten-byte form bytes 2-5
// - set limits records an address range confining the linked chain
// - read inhibit refuses reads within the range
// - write inhibit refuses writes within the range
// - limits block address is the first block of the range
// - limits block count is range length; zero reaches the last block
// - out-of-range or inhibited access is refused with check, data protect
// - second limits command in one chain is refused with check, data protect
// - start/stop enables or disables the unit for media access
// - immediate bit returns status after validation, else after completion
// - load/eject clear takes no medium action
// - load/eject set unloads on stop, loads on start
// - start makes unit ready; stop makes medium inaccessible (a start after an eject, with load/eject clear, leaves the unit not ready)
// - cache is flushed entirely before a stop executes
// - search count of zero searches nothing and is no error
// - unlinked search ends condition met if satisfied, else good
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module bds_cmd_decoder import bds_pkg::*; #(
  parameter int SPIN_COUNT = SPIN_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cache_flush_req,
  input wire logic cache_flush_done,
  output logic medium_load,
  output logic medium_eject,
  output logic seek_strobe,
  output logic [31:0] position,
  output logic unit_ready
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic addr_ok;
  logic go;
  logic end_chain;
  logic record_strobe;

  assign wr_en = psel && penable && pwrite;
  assign addr_ok = (paddr <= ADDR_PATTERN0 + 8'((NUM_DESC - 1) * 4)) && (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign go = wr_en && (paddr == ADDR_CONTROL) && pwdata[CTRL_GO_BIT];
  assign end_chain = wr_en && (paddr == ADDR_CONTROL) && pwdata[CTRL_END_CHAIN_BIT];
  assign record_strobe = wr_en && (paddr == ADDR_RECORD);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [31:0] cdb_word [3];
  logic [31:0] capacity;
  logic [NUM_DESC-1:0] desc_enable;
  logic [31:0] pattern [NUM_DESC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        cdb_word[i] <= 32'h00000000;
      end
      for (int i = 0; i < NUM_DESC; i++) begin
        pattern[i] <= 32'h00000000;
      end
      capacity <= CAPACITY_RESET;
      desc_enable <= '0;
    end else if (wr_en) begin
      if (paddr == ADDR_CDB0) begin
        cdb_word[0] <= pwdata;
      end
      if (paddr == ADDR_CDB1) begin
        cdb_word[1] <= pwdata;
      end
      if (paddr == ADDR_CDB2) begin
        cdb_word[2] <= {16'h0000, pwdata[15:0]};
      end
      if (paddr == ADDR_CAPACITY) begin
        capacity <= pwdata;
      end
      if (paddr == ADDR_DESC_CFG) begin
        desc_enable <= pwdata[NUM_DESC-1:0];
      end
      for (int i = 0; i < NUM_DESC; i++) begin
        if (paddr == ADDR_PATTERN0 + 8'(i * 4)) begin
          pattern[i] <= pwdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command field decode
  // ----------------------------------------------------------------
  logic [7:0] cdb [CDB_BYTES];
  logic [7:0] opcode;
  logic six_byte;
  logic link;
  logic is_search;
  logic is_rw6;
  logic is_rw10;
  logic is_read;
  logic is_write;
  logic is_seek;
  logic is_media;
  logic [31:0] req_lba;
  logic [16:0] req_len;

  always_comb begin
    for (int i = 0; i < CDB_BYTES; i++) begin
      cdb[i] = cdb_word[i / 4][8 * (i % 4) +: 8];
    end
  end

  assign opcode = cdb[0];
  assign six_byte = (opcode[7:5] == 3'b000);
  assign link = six_byte ? cdb[5][LINK_BIT] : cdb[9][LINK_BIT];
  assign is_search = (opcode == OP_SEARCH_EQUAL) || (opcode == OP_SEARCH_HIGH) || (opcode == OP_SEARCH_LOW);
  assign is_rw6 = (opcode == OP_READ6) || (opcode == OP_WRITE6);
  assign is_rw10 = (opcode == OP_READ10) || (opcode == OP_WRITE10);
  assign is_read = (opcode == OP_READ6) || (opcode == OP_READ10) || is_search;
  assign is_write = (opcode == OP_WRITE6) || (opcode == OP_WRITE10);
  assign is_seek = (opcode == OP_SEEK6) || (opcode == OP_SEEK10);
  assign is_media = is_read || is_write || is_seek;
  assign req_lba = six_byte ? {11'h000, cdb[1][4:0], cdb[2], cdb[3]} : {cdb[2], cdb[3], cdb[4], cdb[5]};

  always_comb begin
    if (is_rw6) begin
      req_len = (cdb[4] == 8'h00) ? LEN6_ZERO_BLOCKS : {9'h000, cdb[4]};
    end else if (is_rw10 || is_search) begin
      req_len = {1'b0, cdb[7], cdb[8]};
    end else begin
      req_len = LEN_ONE_BLOCK;
    end
  end

  // ----------------------------------------------------------------
  // limits store and check
  // ----------------------------------------------------------------
  logic limits_active;
  logic [31:0] limit_lba;
  logic [15:0] limit_count;
  logic read_block_flag;
  logic write_block_flag;
  logic violation;
  logic take_limits;
  logic finish;
  logic finish_closes;

  bds_limit_check u_limit_check (
    .limits_active(limits_active),
    .first_lba(limit_lba),
    .block_count(limit_count),
    .last_lba(capacity),
    .read_inhibit(read_block_flag),
    .write_inhibit(write_block_flag),
    .req_lba(req_lba),
    .req_len(req_len),
    .is_read(is_read),
    .is_write(is_write),
    .violation(violation)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limits_active <= 1'b0;
      limit_lba <= 32'h00000000;
      limit_count <= 16'h0000;
      read_block_flag <= 1'b0;
      write_block_flag <= 1'b0;
    end else if (take_limits) begin
      limits_active <= 1'b1;
      limit_lba <= req_lba;
      limit_count <= {cdb[7], cdb[8]};
      read_block_flag <= cdb[1][READ_INH_BIT];
      write_block_flag <= cdb[1][WRITE_INH_BIT];
    end else if ((finish && finish_closes) || end_chain) begin
      limits_active <= 1'b0;
      read_block_flag <= 1'b0;
      write_block_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // search engine
  // ----------------------------------------------------------------
  bds_cmp_type cmp_mode;
  logic cmp_invert;
  logic [NUM_DESC-1:0] desc_match;
  logic all_match;

  assign all_match = &desc_match;

  genvar g;
  generate
    for (g = 0; g < NUM_DESC; g++) begin : gen_desc
      bds_desc_match u_match (
        .record_word(pwdata),
        .pattern(pattern[g]),
        .mode(cmp_mode),
        .invert(cmp_invert),
        .enable(desc_enable[g]),
        .match(desc_match[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  bds_state_type state;
  logic [7:0] status_byte;
  logic [3:0] sense_key;
  logic done;
  logic cmd_link;
  logic stop_pending;
  logic load_unload;
  logic immed_pending;
  logic medium_loaded;
  logic [15:0] search_left;
  logic [31:0] spin_timer;
  logic [7:0] ok_status;

  assign take_limits = go && (state == BDS_IDLE) && (opcode == OP_SET_LIMITS) && !limits_active;
  assign ok_status = link ? ST_INTERMEDIATE : ST_GOOD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= BDS_IDLE;
      status_byte <= ST_GOOD;
      sense_key <= SK_NO_SENSE;
      done <= 1'b0;
      finish <= 1'b0;
      finish_closes <= 1'b0;
      cmd_link <= 1'b0;
      stop_pending <= 1'b0;
      load_unload <= 1'b0;
      immed_pending <= 1'b0;
      medium_loaded <= 1'b1;
      unit_ready <= 1'b1;
      search_left <= 16'h0000;
      spin_timer <= 32'h00000000;
      cmp_mode <= BDS_CMP_EQUAL;
      cmp_invert <= 1'b0;
      position <= 32'h00000000;
      seek_strobe <= 1'b0;
      medium_load <= 1'b0;
      medium_eject <= 1'b0;
    end else begin
      finish <= 1'b0;
      seek_strobe <= 1'b0;
      medium_load <= 1'b0;
      medium_eject <= 1'b0;
      unique case (state)
        BDS_IDLE: begin
          if (go) begin
            done <= 1'b0;
            cmd_link <= link;
            status_byte <= ST_CHECK;
            finish <= 1'b1;
            finish_closes <= 1'b1;
            if (is_media && !unit_ready) begin
              sense_key <= SK_NOT_READY;
            end else if (opcode == OP_SET_LIMITS) begin
              if (limits_active) begin
                sense_key <= SK_DATA_PROTECT;
              end else begin
                status_byte <= ok_status;
                sense_key <= SK_NO_SENSE;
                finish_closes <= !link;
                done <= 1'b1;
              end
            end else if (is_media && violation) begin
              sense_key <= SK_DATA_PROTECT;
            end else if (is_seek || is_rw6 || is_rw10) begin
              status_byte <= ok_status;
              sense_key <= SK_NO_SENSE;
              finish_closes <= !link;
              if (is_seek) begin
                position <= req_lba;
                seek_strobe <= 1'b1;
              end
            end else if (is_search) begin
              sense_key <= SK_NO_SENSE;
              cmp_invert <= cdb[1][INVERT_BIT];
              cmp_mode <= (opcode == OP_SEARCH_HIGH) ? BDS_CMP_HIGH :
                (opcode == OP_SEARCH_LOW) ? BDS_CMP_LOW : BDS_CMP_EQUAL;
              search_left <= req_len[15:0];
              if (req_len == 17'h00000) begin
                status_byte <= ok_status;
                finish_closes <= !link;
              end else begin
                finish <= 1'b0;
                state <= BDS_SEARCH;
              end
            end else if (opcode == OP_START_STOP) begin
              sense_key <= SK_NO_SENSE;
              stop_pending <= !cdb[4][START_BIT];
              load_unload <= cdb[4][LOAD_UNLOAD_BIT];
              immed_pending <= cdb[1][IMMED_BIT];
              if (cdb[1][IMMED_BIT]) begin
                status_byte <= ok_status;
                finish_closes <= !link;
              end else begin
                finish <= 1'b0;
              end
              if (!cdb[4][START_BIT]) begin
                state <= BDS_FLUSH;
              end else begin
                if (cdb[4][LOAD_UNLOAD_BIT]) begin
                  medium_load <= 1'b1;
                  medium_loaded <= 1'b1;
                end
                spin_timer <= 32'(SPIN_COUNT - 1);
                state <= BDS_SPIN;
              end
            end else begin
              sense_key <= SK_ILLEGAL;
            end
          end
        end
        BDS_SEARCH: begin
          if (record_strobe) begin
            search_left <= search_left - 16'h0001;
            if (all_match) begin
              status_byte <= cmd_link ? ST_INTER_COND_MET : ST_COND_MET;
              finish <= 1'b1;
              finish_closes <= !cmd_link;
              state <= BDS_IDLE;
            end else if (search_left == 16'h0001) begin
              status_byte <= cmd_link ? ST_CHECK : ST_GOOD;
              finish <= 1'b1;
              finish_closes <= 1'b1;
              state <= BDS_IDLE;
            end
          end
        end
        BDS_FLUSH: begin
          if (cache_flush_done) begin
            spin_timer <= 32'(SPIN_COUNT - 1);
            state <= BDS_SPIN;
          end
        end
        BDS_SPIN: begin
          if (spin_timer != 32'h00000000) begin
            spin_timer <= spin_timer - 32'h00000001;
          end else begin
            state <= BDS_IDLE;
            if (stop_pending) begin
              unit_ready <= 1'b0;
              if (load_unload) begin
                medium_eject <= 1'b1;
                medium_loaded <= 1'b0;
              end
            end else begin
              unit_ready <= medium_loaded;
            end
            // loading flag clear leaves the medium alone
            if (!immed_pending) begin
              status_byte <= cmd_link ? ST_INTERMEDIATE : ST_GOOD;
              finish <= 1'b1;
              finish_closes <= !cmd_link;
            end
          end
        end
        default: state <= BDS_IDLE;
      endcase
      if (finish) begin
        done <= 1'b1;
      end
    end
  end

  assign cache_flush_req = (state == BDS_FLUSH);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] read_mux;

  always_comb begin
    read_mux = 32'h00000000;
    if (paddr == ADDR_CDB0) begin
      read_mux = cdb_word[0];
    end else if (paddr == ADDR_CDB1) begin
      read_mux = cdb_word[1];
    end else if (paddr == ADDR_CDB2) begin
      read_mux = cdb_word[2];
    end else if (paddr == ADDR_STATUS) begin
      read_mux[7:0] = status_byte;
      read_mux[STS_SENSE_LSB +: 4] = sense_key;
      read_mux[STS_DONE_BIT] = done;
      read_mux[STS_BUSY_BIT] = (state != BDS_IDLE);
      read_mux[STS_READY_BIT] = unit_ready;
      read_mux[STS_LOADED_BIT] = medium_loaded;
      read_mux[STS_LIMITS_BIT] = limits_active;
    end else if (paddr == ADDR_POSITION) begin
      read_mux = position;
    end else if (paddr == ADDR_CAPACITY) begin
      read_mux = capacity;
    end else if (paddr == ADDR_RECORD) begin
      read_mux = {16'h0000, search_left};
    end else if (paddr == ADDR_DESC_CFG) begin
      read_mux[NUM_DESC-1:0] = desc_enable;
    end else begin
      for (int i = 0; i < NUM_DESC; i++) begin
        if (paddr == ADDR_PATTERN0 + 8'(i * 4)) begin
          read_mux = pattern[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= read_mux;
    end
  end

endmodule // bds_cmd_decoder

//--- hw/bds_desc_match.sv
// one search argument descriptor compared against one record word
// assumes record and pattern are unsigned words of equal length
`timescale 1ns/100ps
module bds_desc_match import bds_pkg::*; (
  input wire logic [31:0] record_word,
  input wire logic [31:0] pattern,
  input wire bds_cmp_type mode,
  input wire logic invert,
  input wire logic enable,
  output logic match
);

  logic hit;

  always_comb begin
    unique case (mode)
      BDS_CMP_HIGH: hit = record_word > pattern;
      BDS_CMP_LOW: hit = record_word < pattern;
      default: hit = record_word == pattern;
    endcase
  end

  // invert turns greater into less-or-equal, less into greater-or-equal
  assign match = !enable || (hit ^ invert);

endmodule // bds_desc_match

//--- hw/bds_limit_check.sv
// range and inhibit check of one access against the recorded limits
// assumes limits fields stay stable while limits_active is high
`timescale 1ns/100ps
module bds_limit_check (
  input wire logic limits_active,
  input wire logic [31:0] first_lba,
  input wire logic [15:0] block_count,
  input wire logic [31:0] last_lba,
  input wire logic read_inhibit,
  input wire logic write_inhibit,
  input wire logic [31:0] req_lba,
  input wire logic [16:0] req_len,
  input wire logic is_read,
  input wire logic is_write,
  output logic violation
);

  logic [32:0] req_end;
  logic [32:0] range_end;
  logic outside;

  // zero length still touches its starting block
  assign req_end = (req_len == 17'h00000) ? {1'b0, req_lba} : {1'b0, req_lba} + {16'h0000, req_len} - 33'h000000001;
  assign range_end = (block_count == 16'h0000) ? {1'b0, last_lba} :
    {1'b0, first_lba} + {17'h00000, block_count} - 33'h000000001;
  assign outside = (req_lba < first_lba) || (req_end > range_end);
  assign violation = limits_active && (outside || (is_read && read_inhibit) || (is_write && write_inhibit));

endmodule // bds_limit_check

//--- pkg/bds_pkg.sv
// constants, encodings and register map of the search/seek/limits command decoder
// assumes an APB master with 32-bit data and one aligned word per register
package bds_pkg;

  // ----------------------------------------------------------------
  // command operation codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SEARCH_HIGH = 8'h30;
  localparam logic [7:0] OP_SEARCH_EQUAL = 8'h31;
  localparam logic [7:0] OP_SEARCH_LOW = 8'h32;
  localparam logic [7:0] OP_SET_LIMITS = 8'h33;
  localparam logic [7:0] OP_SEEK6 = 8'h0b;
  localparam logic [7:0] OP_SEEK10 = 8'h2b;
  localparam logic [7:0] OP_START_STOP = 8'h1b;
  localparam logic [7:0] OP_READ6 = 8'h08;
  localparam logic [7:0] OP_READ10 = 8'h28;
  localparam logic [7:0] OP_WRITE6 = 8'h0a;
  localparam logic [7:0] OP_WRITE10 = 8'h2a;

  // ----------------------------------------------------------------
  // command block field positions
  // ----------------------------------------------------------------
  localparam int CDB_BYTES = 10;
  localparam int LINK_BIT = 0;
  localparam int INVERT_BIT = 4;
  localparam int READ_INH_BIT = 1;
  localparam int WRITE_INH_BIT = 0;
  localparam int IMMED_BIT = 0;
  localparam int LOAD_UNLOAD_BIT = 1;
  localparam int START_BIT = 0;
  localparam logic [16:0] LEN6_ZERO_BLOCKS = 17'h00100;
  localparam logic [16:0] LEN_ONE_BLOCK = 17'h00001;

  // ----------------------------------------------------------------
  // status bytes and sense keys
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_COND_MET = 8'h04;
  localparam logic [7:0] ST_INTERMEDIATE = 8'h10;
  localparam logic [7:0] ST_INTER_COND_MET = 8'h14;
  localparam logic [3:0] SK_NO_SENSE = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_DATA_PROTECT = 4'h7;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CDB0 = 8'h00;
  localparam logic [7:0] ADDR_CDB1 = 8'h04;
  localparam logic [7:0] ADDR_CDB2 = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_POSITION = 8'h14;
  localparam logic [7:0] ADDR_CAPACITY = 8'h18;
  localparam logic [7:0] ADDR_RECORD = 8'h1c;
  localparam logic [7:0] ADDR_DESC_CFG = 8'h20;
  localparam logic [7:0] ADDR_PATTERN0 = 8'h24;
  localparam int NUM_DESC = 2;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_END_CHAIN_BIT = 1;
  localparam int STS_SENSE_LSB = 8;
  localparam int STS_DONE_BIT = 16;
  localparam int STS_BUSY_BIT = 17;
  localparam int STS_READY_BIT = 18;
  localparam int STS_LOADED_BIT = 19;
  localparam int STS_LIMITS_BIT = 20;
  localparam logic [31:0] CAPACITY_RESET = 32'h000fffff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SPIN_TIME_US = 1000;
  localparam int SPIN_CYCLES = (SPIN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    BDS_CMP_EQUAL = 2'b00,
    BDS_CMP_HIGH = 2'b01,
    BDS_CMP_LOW = 2'b10
  } bds_cmp_type;

  typedef enum logic [1:0] {
    BDS_IDLE = 2'b00,
    BDS_SEARCH = 2'b01,
    BDS_FLUSH = 2'b10,
    BDS_SPIN = 2'b11
  } bds_state_type;

endpackage

//--- test/bds_cache_model.sv
// cache partner: answers each flush request after a short delay
// assumes the request is a level held until done is seen
`timescale 1ns/100ps
module bds_cache_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cache_flush_req,
  output logic cache_flush_done
);
  logic [1:0] dly;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly <= 2'h0;
      cache_flush_done <= 1'b0;
    end else begin
      dly <= (cache_flush_req && !cache_flush_done) ? dly + 2'h1 : 2'h0;
      cache_flush_done <= cache_flush_req && dly == 2'h3;
    end
  end
endmodule // bds_cache_model

//--- test/bds_chk.sv
// checker: port relations of the command decoder
// assumes bound to bds_cmd_decoder with a short spin count
`timescale 1ns/100ps
module bds_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic cache_flush_req,
  input wire logic cache_flush_done,
  input wire logic medium_load,
  input wire logic medium_eject,
  input wire logic seek_strobe,
  input wire logic [31:0] position,
  input wire logic unit_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence flush_end;
    cache_flush_req && cache_flush_done && unit_ready;
  endsequence
  sequence stop_spin;
    unit_ready ##[1:12] !unit_ready;
  endsequence
  chk_flush_ends: assert property (flush_end |=> !cache_flush_req)
    else $error("flush request held after done");
  chk_stop_after_flush: assert property (flush_end |=> stop_spin)
    else $error("unit not stopped after flush");
  chk_eject_stopped: assert property (medium_eject |-> !unit_ready)
    else $error("eject while unit ready");
  chk_load_start: assert property (medium_load |-> ##[1:12] unit_ready)
    else $error("unit not ready after load");
  chk_one_action: assert property (!(medium_load && medium_eject))
    else $error("load and eject together");
  chk_seek_ready: assert property (seek_strobe |-> unit_ready)
    else $error("seek while stopped");
  chk_pos_hold: assert property (!seek_strobe |-> $stable(position))
    else $error("position moved without seek");
  chk_err_map: assert property (pslverr == (psel && penable && (paddr > 8'h28 || paddr[1:0] != 2'b00)))
    else $error("bad slave error");
endmodule // bds_chk
bind bds_cmd_decoder bds_chk u_chk (.*);

//--- test/tb.sv
// testbench: drives the decoder over APB and checks command outcomes
// assumes the cache model answers flush requests
`timescale 1ns/100ps
module tb;
  import bds_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, position, q;
  logic pready, pslverr, cache_flush_req, cache_flush_done, medium_load, medium_eject, seek_strobe, unit_ready, e;
  int n_errors = 0, checked = 0, k;
  logic [7:0] ops [7] = '{8'h31, 8'h31, 8'h30, 8'h30, 8'h30, 8'h32, 8'h32};
  logic inv [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] recs [7] = '{8'h64, 8'h64, 8'h65, 8'h64, 8'h64, 8'h63, 8'h64};
  logic [7:0] sts [7] = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h00, 8'h04, 8'h04};
  always #25 pclk = ~pclk;
  bds_cmd_decoder #(.SPIN_COUNT(4)) dut (.*);
  bds_cache_model u_cache (.*);
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] c0, input logic [31:0] c1, input logic [31:0] c2);
    apb(1'b1, ADDR_CDB0, c0);
    apb(1'b1, ADDR_CDB1, c1);
    apb(1'b1, ADDR_CDB2, c2);
    apb(1'b1, ADDR_CONTROL, 32'h1);
  endtask
  // poll done, then compare sense and status byte
  task automatic fin(input logic [11:0] exp);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      if (q[STS_DONE_BIT] === 1'b1) break;
    end
    cmp({20'h0, q[11:0]}, {20'h0, exp});
  endtask
  task automatic lim(input logic [1:0] inh, input logic [7:0] cnt);
    cmd({22'h0, inh, OP_SET_LIMITS}, 32'h1, {16'h0, 8'h01, cnt});
  endtask
  task automatic acc(input logic [7:0] op, input logic [15:0] lba, input logic lnk);
    cmd({24'h0, op}, {16'h0, lba[7:0], lba[15:8]}, {23'h0, lnk, 8'h01});
  endtask
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CAPACITY, 32'h0);
    cmp(q, CAPACITY_RESET);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp(q, 32'h000c0000);
    apb(1'b0, 8'h2c, 32'h0);
    cmp({q[30:0], e}, 32'h1);
    apb(1'b1, ADDR_DESC_CFG, 32'h1);
    apb(1'b1, ADDR_PATTERN0, 32'h64);
    apb(1'b1, ADDR_PATTERN0 + 8'h04, 32'h70);
    for (k = 0; k < 7; k++) begin
      cmd({19'h0, inv[k], 4'h0, ops[k]}, 32'h0, 32'h1);
      apb(1'b1, ADDR_RECORD, {24'h0, recs[k]});
      fin({4'h0, sts[k]});
    end
    apb(1'b1, ADDR_DESC_CFG, 32'h3);
    cmd({24'h0, OP_SEARCH_HIGH}, 32'h0, 32'h2);
    apb(1'b1, ADDR_RECORD, 32'h68);
    apb(1'b1, ADDR_RECORD, 32'h60);
    fin(12'h000);
    cmd({24'h0, OP_SEARCH_HIGH}, 32'h0, 32'h3);
    apb(1'b1, ADDR_RECORD, 32'h68);
    apb(1'b1, ADDR_RECORD, 32'h80);
    fin(12'h004);
    cmd({24'h0, OP_SEARCH_HIGH}, 32'h0, 32'h101);
    apb(1'b1, ADDR_RECORD, 32'h80);
    fin(12'h014);
    cmd({24'h0, OP_SEARCH_EQUAL}, 32'h0, 32'h0);
    fin(12'h000);
    cmd(32'h3412002b, 32'h00007856, 32'h0);
    fin(12'h000);
    cmp(position, 32'h12345678);
    cmd(32'h0302010b, 32'h0, 32'h0);
    fin(12'h000);
    cmp(position, 32'h00010203);
    cmd(32'h000000ff, 32'h0, 32'h0);
    fin(12'h502);
    lim(2'b01, 8'h10);
    fin(12'h010);
    cmp(q[STS_LIMITS_BIT], 1'b1);
    acc(OP_READ10, 16'h0100, 1'b1);
    fin(12'h010);
    acc(OP_WRITE10, 16'h010f, 1'b1);
    fin(12'h702);
    lim(2'b10, 8'h10);
    fin(12'h010);
    acc(OP_READ10, 16'h0105, 1'b1);
    fin(12'h702);
    lim(2'b00, 8'h10);
    fin(12'h010);
    acc(OP_READ10, 16'h0110, 1'b1);
    fin(12'h702);
    lim(2'b00, 8'h10);
    fin(12'h010);
    lim(2'b00, 8'h10);
    fin(12'h702);
    apb(1'b1, ADDR_CAPACITY, 32'h1000);
    lim(2'b01, 8'h00);
    fin(12'h010);
    acc(OP_READ10, 16'h0ff0, 1'b1);
    fin(12'h010);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp(q[STS_LIMITS_BIT], 1'b0);
    lim(2'b01, 8'h00);
    fin(12'h010);
    acc(OP_READ10, 16'h0110, 1'b0);
    fin(12'h000);
    acc(OP_READ10, 16'h00ff, 1'b0);
    fin(12'h000);
    cmd(32'h0000001b, 32'h2, 32'h0);
    fin(12'h000);
    cmp(q[20:16], 5'h01);
    cmd(32'h0000002b, 32'h0, 32'h0);
    fin(12'h202);
    cmd(32'h0000011b, 32'h3, 32'h0);
    fin(12'h000);
    cmp(q[STS_BUSY_BIT], 1'b1);
    for (k = 0; k < 50 && unit_ready !== 1'b1; k++) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp(q, 32'h000d0000);
    cmd(32'h0000001b, 32'h0, 32'h0);
    fin(12'h000);
    cmp(q[20:16], 5'h09);
    tally_and_finish();
  end
endmodule // tb
